// ===== rtl/alu_params.svh
// Offsets, field positions, reset values and widths for the add-and-shift ALU.
// Assumes inclusion by the ALU package and the ALU design module.
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

// Register byte offsets on the bus
`define OFS_ACC        8'h00
`define OFS_STATUS     8'h04
`define OFS_PTR0       8'h08
`define OFS_PTR1       8'h0C
`define OFS_LAST       8'h10

// Status field positions
`define BIT_CARRY      0
`define BIT_HALF_CARRY 1
`define BIT_ZERO       2

// Reset values
`define RST_ACC        8'h00
`define RST_PTR        16'h0000
`define RST_FLAGS      3'h0

// Operand widths
`define FILE_ADDR_W    7
`define PTR_LIT_W      6

`endif

// ===== rtl/alu_pkg.sv
// Types shared by the ALU design and its bench.
// Assumes the params header sits beside it.
package alu_pkg;
  `include "alu_params.svh"

  // Instruction group decoded upstream
  typedef enum logic [2:0] {
    op_idle,
    pointer_add_literal,
    and_literal_acc,
    add_literal_acc,
    and_acc_file,
    add_acc_file,
    add_acc_file_carry,
    arith_shift_right_file
  } op_type;

  // Whole state of the ALU
  typedef struct packed {
    logic [7:0]                acc;
    logic                      carry;
    logic                      half_carry;
    logic                      zero;
    logic [15:0]               ptr0;
    logic [15:0]               ptr1;
    logic [7:0]                last;
    logic                      file_we;
    logic [`FILE_ADDR_W-1:0]   file_waddr;
    logic [7:0]                file_wdata;
    logic                      done;
    logic                      ack;
    logic [31:0]               rdata;
  } state_type;
endpackage

// ===== rtl/core_add_and_shift_alu.sv
// Add, AND and shift datapath of an 8-bit core with its flags and pointers.
// Assumes the decoder and data memory run on clk; file data arrives in the
// same cycle as the instruction; software reaches state over classic Wishbone.
`timescale 1ns/100ps
`include "alu_params.svh"

// What this block does
// - Pointer add sign-extends a 6-bit literal into pointer 0 or 1, flags kept.
// - Pointer sums wrap modulo 65536, never saturate.
// - AND literal with accumulator, result to accumulator, only zero flag changes.
// - Add literal to accumulator, result to accumulator, carry half-carry zero change.
// - AND accumulator with file register, result to chosen destination, zero only.
// - Add accumulator and file register to chosen destination, three flags change.
// - Add accumulator, file register and carry to chosen destination, three flags.
// - Arithmetic right shift keeps bit 7, bit 0 goes to carry, carry zero change.
// - Destination bit 0 selects accumulator, 1 writes back into the file register.
// - File address is 7 bits covering 0 to 127; destination is one bit.
module core_add_and_shift_alu
  import alu_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  // Instruction from the decoder
  input  wire logic                    instr_valid,
  input  op_type                       opcode,
  input  wire logic [`FILE_ADDR_W-1:0] file_addr,
  input  wire logic                    dest_sel,
  input  wire logic [7:0]              literal,
  input  wire logic                    ptr_sel,
  input  wire logic [7:0]              file_rdata,
  output wire logic                    instr_done,
  // Data memory write-back
  output wire logic                    file_we,
  output wire logic [`FILE_ADDR_W-1:0] file_waddr,
  output wire logic [7:0]              file_wdata,
  // Core state seen by the rest of the core
  output wire logic [7:0]              acc_value,
  output wire logic                    carry_flag,
  output wire logic                    half_carry_flag,
  output wire logic                    zero_flag,
  output wire logic [15:0]             pointer0,
  output wire logic [15:0]             pointer1,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output wire logic [31:0]             wb_dat_o,
  output wire logic                    wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Returns {carry, half_carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // Zero test on an 8-bit result
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_type st_r;
  state_type st_nxt;

  logic        bus_req;
  logic        bus_wr;
  logic [9:0]  add_res;
  logic [7:0]  res;
  logic [15:0] ptr_off;

  assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign bus_wr  = bus_req & wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus access first, instruction overrides on collision
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.file_we = 1'b0;
    st_nxt.done    = 1'b0;
    st_nxt.ack     = 1'b0;
    add_res        = 10'h000;
    res            = 8'h00;
    ptr_off        = {{(16-`PTR_LIT_W){literal[`PTR_LIT_W-1]}}, literal[`PTR_LIT_W-1:0]};

    // Bus slave: one-cycle answer, unmapped reads as zero
    if (bus_req)
    begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      case (wb_adr_i)
        `OFS_ACC:
        begin
          st_nxt.rdata[7:0] = st_r.acc;
          if (wb_we_i && wb_sel_i[0])
            st_nxt.acc = wb_dat_i[7:0];
        end
        `OFS_STATUS:
        begin
          st_nxt.rdata[`BIT_CARRY]      = st_r.carry;
          st_nxt.rdata[`BIT_HALF_CARRY] = st_r.half_carry;
          st_nxt.rdata[`BIT_ZERO]       = st_r.zero;
          if (wb_we_i && wb_sel_i[0])
          begin
            st_nxt.carry      = wb_dat_i[`BIT_CARRY];
            st_nxt.half_carry = wb_dat_i[`BIT_HALF_CARRY];
            st_nxt.zero       = wb_dat_i[`BIT_ZERO];
          end
        end
        `OFS_PTR0:
        begin
          st_nxt.rdata[15:0] = st_r.ptr0;
          if (wb_we_i && wb_sel_i[0])
            st_nxt.ptr0[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            st_nxt.ptr0[15:8] = wb_dat_i[15:8];
        end
        `OFS_PTR1:
        begin
          st_nxt.rdata[15:0] = st_r.ptr1;
          if (wb_we_i && wb_sel_i[0])
            st_nxt.ptr1[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            st_nxt.ptr1[15:8] = wb_dat_i[15:8];
        end
        `OFS_LAST:
          st_nxt.rdata[7:0] = st_r.last;
        default:
          st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Instruction execution, one per cycle
    if (instr_valid)
    begin
      st_nxt.done = (opcode != op_idle);
      case (opcode)
        pointer_add_literal:
        begin
          // 16-bit sum drops the carry so it wraps
          if (ptr_sel)
            st_nxt.ptr1 = st_r.ptr1 + ptr_off;
          else
            st_nxt.ptr0 = st_r.ptr0 + ptr_off;
        end
        and_literal_acc:
        begin
          res         = st_r.acc & literal;
          st_nxt.acc  = res;
          st_nxt.zero = is_zero(res);
        end
        add_literal_acc:
        begin
          add_res           = add8(st_r.acc, literal, 1'b0);
          res               = add_res[7:0];
          st_nxt.acc        = res;
          st_nxt.carry      = add_res[9];
          st_nxt.half_carry = add_res[8];
          st_nxt.zero       = is_zero(res);
        end
        and_acc_file:
        begin
          res         = st_r.acc & file_rdata;
          st_nxt.zero = is_zero(res);
        end
        add_acc_file:
        begin
          add_res           = add8(st_r.acc, file_rdata, 1'b0);
          res               = add_res[7:0];
          st_nxt.carry      = add_res[9];
          st_nxt.half_carry = add_res[8];
          st_nxt.zero       = is_zero(res);
        end
        add_acc_file_carry:
        begin
          add_res           = add8(st_r.acc, file_rdata, st_r.carry);
          res               = add_res[7:0];
          st_nxt.carry      = add_res[9];
          st_nxt.half_carry = add_res[8];
          st_nxt.zero       = is_zero(res);
        end
        arith_shift_right_file:
        begin
          res          = {file_rdata[7], file_rdata[7:1]};
          st_nxt.carry = file_rdata[0];
          st_nxt.zero  = is_zero(res);
        end
        default:
          res = 8'h00;
      endcase

      // Destination select for file-register forms
      if (opcode == and_acc_file || opcode == add_acc_file ||
          opcode == add_acc_file_carry || opcode == arith_shift_right_file)
      begin
        st_nxt.last = res;
        if (dest_sel)
        begin
          st_nxt.file_we    = 1'b1;
          st_nxt.file_waddr = file_addr;
          st_nxt.file_wdata = res;
        end
        else
          st_nxt.acc = res;
      end
      else if (opcode == and_literal_acc || opcode == add_literal_acc)
        st_nxt.last = res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  // Outputs straight from state
  assign instr_done      = st_r.done;
  assign file_we         = st_r.file_we;
  assign file_waddr      = st_r.file_waddr;
  assign file_wdata      = st_r.file_wdata;
  assign acc_value       = st_r.acc;
  assign carry_flag      = st_r.carry;
  assign half_carry_flag = st_r.half_carry;
  assign zero_flag       = st_r.zero;
  assign pointer0        = st_r.ptr0;
  assign pointer1        = st_r.ptr1;
  assign wb_dat_o        = st_r.rdata;
  assign wb_ack_o        = st_r.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ptr_flags_kept: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == pointer_add_literal && !bus_wr) |=>
      (carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag)
       && half_carry_flag == $past(half_carry_flag)))
    else $error("pointer add changed a flag");

  a_ptr_wrap_sum: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == pointer_add_literal && !ptr_sel) |=>
      pointer0 == 16'($past(pointer0) + {{10{$past(literal[5])}}, $past(literal[5:0])}))
    else $error("pointer 0 sum wrong");

  a_and_lit_acc: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == and_literal_acc && !bus_wr) |=>
      (acc_value == ($past(acc_value) & $past(literal))
       && carry_flag == $past(carry_flag)))
    else $error("AND literal result wrong");

  a_add_lit_acc: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == add_literal_acc) |=>
      {carry_flag, acc_value} == {1'b0, $past(acc_value)} + {1'b0, $past(literal)})
    else $error("add literal result wrong");

  a_and_file_res: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == and_acc_file && dest_sel) |=>
      (file_wdata == ($past(acc_value) & $past(file_rdata)) && file_we))
    else $error("AND file result wrong");

  a_add_file_sum: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == add_acc_file && !dest_sel) |=>
      {carry_flag, acc_value} == {1'b0, $past(acc_value)} + {1'b0, $past(file_rdata)})
    else $error("add file result wrong");

  a_addc_file_sum: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == add_acc_file_carry && !dest_sel) |=>
      {carry_flag, acc_value} == {1'b0, $past(acc_value)} + {1'b0, $past(file_rdata)}
        + {8'h00, $past(carry_flag)})
    else $error("add with carry result wrong");

  a_asr_shift: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == arith_shift_right_file && dest_sel) |=>
      (file_wdata == {$past(file_rdata[7]), $past(file_rdata[7:1])}
       && carry_flag == $past(file_rdata[0])))
    else $error("shift result wrong");

  a_dest_routing: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == add_acc_file && dest_sel && !bus_wr) |=>
      (file_we && file_waddr == $past(file_addr) && acc_value == $past(acc_value)))
    else $error("destination routing wrong");

  a_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode != op_idle && opcode != pointer_add_literal) |=>
      (zero_flag == (st_r.last == 8'h00)))
    else $error("zero flag wrong");

  a_half_carry: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == add_literal_acc) |=>
      half_carry_flag == (({1'b0, $past(acc_value[3:0])} + {1'b0, $past(literal[3:0])}) > 5'd15))
    else $error("half-carry wrong");

  a_ptr1_wrap_sum: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == pointer_add_literal && ptr_sel) |=>
      pointer1 == 16'($past(pointer1) + {{10{$past(literal[5])}}, $past(literal[5:0])}))
    else $error("pointer 1 sum wrong");

  a_and_file_acc: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == and_acc_file && !dest_sel && !bus_wr) |=>
      (acc_value == ($past(acc_value) & $past(file_rdata)) && !file_we
       && carry_flag == $past(carry_flag)
       && half_carry_flag == $past(half_carry_flag)))
    else $error("AND file to accumulator wrong");

  a_asr_half_kept: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && opcode == arith_shift_right_file && !bus_wr) |=>
      half_carry_flag == $past(half_carry_flag))
    else $error("shift changed half-carry");

  a_lit_no_write: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid
     && opcode inside {pointer_add_literal, and_literal_acc, add_literal_acc}) |=>
      !file_we)
    else $error("literal form wrote a file register");

  a_file_waddr: assert property (@(posedge clk) disable iff (!resetn)
    (ce && instr_valid && dest_sel && opcode inside {and_acc_file, add_acc_file,
      add_acc_file_carry, arith_shift_right_file}) |=>
      (file_we && file_waddr == $past(file_addr)))
    else $error("file write-back address wrong");

  a_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
    ce |=> (instr_done == ($past(instr_valid) && $past(opcode) != op_idle)))
    else $error("instruction done pulse wrong");

  a_ack_answer: assert property (@(posedge clk) disable iff (!resetn)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered");

  a_ack_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("bus acknowledge held too long");

endmodule

// ===== verification/file_memory_model.sv
// Data memory model standing behind the ALU's file register port.
// Assumes reads are combinational and write-back lands on the rising clk edge.
`timescale 1ns/100ps

module file_memory_model
(
  // Clock
  input  wire logic       clk,
  // Read side
  input  wire logic [6:0] file_addr,
  output logic [7:0]      file_rdata,
  // Write-back side
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];

  ////////////////////////////////////////////////////////////////////////////
  // Operand answered in the same cycle as the address
  assign file_rdata = mem[file_addr];

  // Write-back of file destination results
  always @(posedge clk)
  begin
    if (file_we)
      mem[file_waddr] <= file_wdata;
  end
endmodule

// ===== verification/core_add_and_shift_alu_tb.sv
// Self-checking bench for the add, AND and shift datapath.
// Assumes the memory model beside it and the shared ALU package.
`timescale 1ns/100ps
`include "alu_params.svh"

module core_add_and_shift_alu_tb;
  import alu_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, instr_valid = 0, dest_sel = 0, ptr_sel = 0;
  op_type opcode = op_idle;
  logic [6:0] file_addr = 0, file_waddr;
  logic [7:0] literal = 0, file_rdata, file_wdata, acc_value;
  logic instr_done, file_we, carry_flag, half_carry_flag, zero_flag, wb_ack_o;
  logic [15:0] pointer0, pointer1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  int n_errors = 0, n_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #4 clk = ~clk;

  core_add_and_shift_alu DUT (.clk(clk), .resetn(resetn), .ce(ce),
    .instr_valid(instr_valid), .opcode(opcode), .file_addr(file_addr),
    .dest_sel(dest_sel), .literal(literal), .ptr_sel(ptr_sel),
    .file_rdata(file_rdata), .instr_done(instr_done), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_value(acc_value),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .zero_flag(zero_flag), .pointer0(pointer0), .pointer1(pointer1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  file_memory_model mem_i (.clk(clk), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Classic single Wishbone cycle, waits for ack
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] d, logic [3:0] s,
                    output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= ad;
    wb_dat_i <= d; wb_sel_i <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask

  // One instruction, outputs settled after the taking edge
  task automatic exec(op_type op, logic [6:0] a, logic d, logic [7:0] l, logic p);
    @(posedge clk);
    instr_valid <= 1; opcode <= op; file_addr <= a; dest_sel <= d;
    literal <= l; ptr_sel <= p;
    @(posedge clk);
    instr_valid <= 0; opcode <= op_idle;
    #1;
  endtask

  // Reference result {zero, half_carry, carry, result}
  function automatic logic [10:0] ref_alu(op_type op, logic [7:0] a, f, l,
                                          logic [2:0] st);
    logic [8:0] s = 0;
    logic [4:0] h = 0;
    logic [10:0] r = {st, a};
    case (op)
      and_literal_acc:    r[7:0] = a & l;
      and_acc_file:       r[7:0] = a & f;
      add_literal_acc:    begin s = a + l; h = a[3:0] + l[3:0]; end
      add_acc_file:       begin s = a + f; h = a[3:0] + f[3:0]; end
      add_acc_file_carry: begin s = a + f + st[0]; h = a[3:0] + f[3:0] + st[0]; end
      default:            begin r[7:0] = {f[7], f[7:1]}; r[8] = f[0]; end
    endcase
    if (op inside {add_literal_acc, add_acc_file, add_acc_file_carry})
      r[9:0] = {h[4], s};
    r[10] = (r[7:0] == 8'h00);
    return r;
  endfunction

  // Preset state, run one operation, judge destination and flags
  task automatic op_case(op_type op, logic [7:0] a, logic [2:0] st, logic [7:0] f,
                         logic d, logic [7:0] l, logic [6:0] ad);
    logic [31:0] q;
    logic [10:0] e = ref_alu(op, a, f, l, st);
    wb(1, `OFS_ACC, {24'h00_0000, a}, 4'b0001, q);
    wb(1, `OFS_STATUS, {29'h0000_0000, st}, 4'b0001, q);
    mem_i.mem[ad] = f;
    exec(op, ad, d, l, 1'b0);
    chk(32'(instr_done), 1);
    chk(32'({zero_flag, half_carry_flag, carry_flag}), 32'(e[10:8]));
    if (d && !(op inside {and_literal_acc, add_literal_acc}))
    begin
      chk(32'({file_we, file_waddr, file_wdata}), {16'h0, 1'b1, ad, e[7:0]});
      chk(32'(acc_value), 32'(a));
    end
    else
    begin
      chk(32'({file_we, acc_value}), 32'(e[7:0]));
    end
    wb(0, `OFS_LAST, 0, 4'hF, q);
    chk(32'(q[7:0]), 32'(e[7:0]));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    chk(32'({acc_value, pointer0, carry_flag, half_carry_flag, zero_flag}), 0);
    chk(32'(pointer1), 0);
    // Four mapped offsets, then one unmapped
    for (int i = 0; i < 5; i++)
    begin
      wb(0, i == 4 ? 8'h20 : 8'(i * 4), 0, 4'hF, q);
      chk(q, 0);
    end
    wb(1, `OFS_LAST, 32'h0000_00FF, 4'hF, q);
    wb(0, `OFS_LAST, 0, 4'hF, q);
    chk(q, 0);
    $display("reset test done");
  endtask

  task automatic t_literal;
    op_case(add_literal_acc, 8'hF8, 3'b000, 8'h00, 0, 8'h08, 0);
    op_case(add_literal_acc, 8'h0F, 3'b111, 8'h00, 1, 8'h01, 0);
    op_case(and_literal_acc, 8'h3C, 3'b011, 8'h00, 0, 8'hC3, 0);
    op_case(and_literal_acc, 8'hFF, 3'b100, 8'h00, 1, 8'hFF, 0);
    $display("literal test done");
  endtask

  task automatic t_file;
    op_type ops[4] = '{and_acc_file, add_acc_file, add_acc_file_carry,
                       arith_shift_right_file};
    foreach (ops[i])
      for (int d = 0; d < 2; d++)
        op_case(ops[i], 8'h9A, {2'b01, d[0]}, 8'hA7, d[0], 8'h00, d ? 7'h7F : 7'h00);
    op_case(add_acc_file_carry, 8'hFF, 3'b001, 8'h00, 1, 8'h00, 7'h55);
    op_case(arith_shift_right_file, 8'h11, 3'b110, 8'h01, 0, 8'h00, 7'h2A);
    $display("file test done");
  endtask

  task automatic t_pointer;
    logic [31:0] q;
    wb(1, `OFS_PTR0, 32'h0000_FFF0, 4'b0011, q);
    wb(1, `OFS_PTR1, 32'h0000_0010, 4'b0011, q);
    wb(1, `OFS_STATUS, 32'h0000_0005, 4'b0001, q);
    exec(pointer_add_literal, 0, 0, 8'h1F, 0);
    chk(32'(pointer0), 32'h0000_000F);
    exec(pointer_add_literal, 0, 0, 8'hE0, 1);
    chk(32'(pointer1), 32'h0000_FFF0);
    chk(32'({zero_flag, half_carry_flag, carry_flag, pointer0}), 32'h0005_000F);
    wb(0, `OFS_PTR1, 0, 4'hF, q);
    chk(q, 32'h0000_FFF0);
    $display("pointer test done");
  endtask

  // Enable low freezes a pending instruction, then a mid-run reset clears state
  task automatic t_freeze;
    logic [31:0] q;
    wb(1, `OFS_ACC, 32'h0000_0055, 4'b0001, q);
    @(posedge clk);
    ce          <= 0;
    instr_valid <= 1;
    opcode      <= add_literal_acc;
    literal     <= 8'h01;
    repeat (3) @(posedge clk);
    ce          <= 1;
    instr_valid <= 0;
    opcode      <= op_idle;
    #1;
    chk(32'({instr_done, acc_value}), 32'h0000_0055);
    @(posedge clk);
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    #1;
    chk(32'({acc_value, carry_flag, half_carry_flag, zero_flag, pointer1}), 0);
    chk(32'(pointer0), 0);
    wb(0, `OFS_ACC, 0, 4'hF, q);
    chk(q, 0);
    $display("freeze and reset test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_literal();
    t_file();
    t_pointer();
    t_freeze();
    close_out();
  end

  initial
  begin
    #200_000;
    n_errors++;
    close_out();
  end
endmodule
